// ---- gsl_pkg.sv ----
// Operation
// - each shift-clock rise captures the serial input into the shift register bit 0
// - each shift-clock rise moves every stored bit one place toward the MSB
// - an extra stage after the MSB drives the cascade output, updated on falls
// - cascade output shows the shift register MSB, changing only on falling edges
// - strobe rise snapshots the whole shift register; the frame fifo passes it to the grayscale latch at a period start
// - after a strobe rise all 24 channels stay off until the next period
// - strobe rise leaves the grayscale counter running, never cleared to zero
// - blank high forces channels off and clears counter; low lets PWM drive channels
// - each channel on-time set by its latched 12-bit value, period repeats
`default_nettype none
package gsl_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // geometry of the grayscale path
    localparam int unsigned GSL_CHANNELS = 24;
    localparam int unsigned GSL_GRAY_BITS = 12;
    localparam int unsigned GSL_FRAME_BITS = GSL_CHANNELS * GSL_GRAY_BITS;
    localparam int unsigned GSL_FIFO_DEPTH = 16;
    localparam int unsigned GSL_PWM_STEPS = 4096;

    ////////////////////////////////////////////////////////////////////////////
    // reset values and counter step
    localparam logic [GSL_GRAY_BITS-1:0] GSL_CNT_RESET = 12'h000;
    localparam logic [GSL_GRAY_BITS-1:0] GSL_CNT_STEP = 12'h001;
    localparam logic [GSL_FRAME_BITS-1:0] GSL_FRAME_RESET = '0;
    localparam logic GSL_BIT_RESET = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // timing: strobe rise to next shift-clock rise, kept by the controller
    localparam int unsigned GSL_CLK_NS = 10;
    localparam int unsigned GSL_STROBE_SETUP_NS = 100;
    localparam int unsigned GSL_STROBE_SETUP_CYC =
        (GSL_STROBE_SETUP_NS + GSL_CLK_NS - 1) / GSL_CLK_NS;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef logic [GSL_GRAY_BITS-1:0] gsl_gray_t;
    typedef logic [GSL_FRAME_BITS-1:0] gsl_frame_t;
    typedef logic [GSL_CHANNELS-1:0] gsl_chan_t;

    // pins sampled together through the synchroniser
    typedef struct packed {
        logic sclk;
        logic ser;
        logic strobe;
        logic blank;
    } gsl_pins_s;

    // latch loader states
    typedef enum logic [1:0] {
        GSL_ST_IDLE = 2'b01,
        GSL_ST_PEND = 2'b10
    } gsl_load_e;

endpackage : gsl_pkg
`default_nettype wire

// ---- gsl_fifo.sv ----
`timescale 1ns/10ps
`default_nettype none
module gsl_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam logic [AW:0] PTR_STEP = 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_ff;
    logic [AW:0] rd_ptr_ff;
    logic out_valid_ff;
    logic [WIDTH-1:0] out_data_ff;

    ////////////////////////////////////////////////////////////////////////////
    // full and empty from pointers with a wrap bit
    wire full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
    wire empty = (wr_ptr_ff == rd_ptr_ff);
    wire push = in_valid && !full;
    wire load = !empty && (!out_valid_ff || out_ready);

    assign in_ready = !full;
    assign out_valid = out_valid_ff;
    assign out_data = out_data_ff;

    // storage, no reset
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_ff[AW-1:0]] <= in_data;
        end
    end

    // pointers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            wr_ptr_ff <= push ? wr_ptr_ff + PTR_STEP : wr_ptr_ff;
            rd_ptr_ff <= load ? rd_ptr_ff + PTR_STEP : rd_ptr_ff;
        end
    end

    // registered read stage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_valid_ff <= 1'b0;
            out_data_ff <= '0;
        end else if (load) begin
            out_valid_ff <= 1'b1;
            out_data_ff <= mem[rd_ptr_ff[AW-1:0]];
        end else if (out_ready) begin
            out_valid_ff <= 1'b0;
        end
    end

endmodule : gsl_fifo
`default_nettype wire

// ---- gsl_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module gsl_top
    import gsl_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic SCLK,
    input wire logic SERIAL_IN,
    input wire logic LATCH_STROBE,
    input wire logic BLANK,
    output logic CASCADE_SERIAL_OUT,
    output logic [GSL_CHANNELS-1:0] CHANNEL_SINK_OUTPUT
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    gsl_pins_s pins_raw;
    gsl_pins_s pins_meta_ff;
    gsl_pins_s pins_sync_ff;
    gsl_pins_s pins_last_ff;

    gsl_frame_t shift_ff;
    gsl_frame_t nxt_shift;
    logic cascade_ff;
    logic nxt_cascade;

    gsl_load_e load_state_ff;
    gsl_load_e nxt_load_state;
    gsl_frame_t snapshot_ff;
    gsl_frame_t nxt_snapshot;

    gsl_frame_t gray_latch_ff;
    gsl_frame_t nxt_gray_latch;
    gsl_gray_t cnt_ff;
    gsl_gray_t nxt_cnt;
    logic hold_off_ff;
    logic nxt_hold_off;
    gsl_chan_t sink_ff;
    gsl_chan_t nxt_sink;

    logic fifo_in_ready;
    logic fifo_out_valid;
    gsl_frame_t fifo_out_data;
    logic period_start;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchroniser, two flops then an edge history stage
    assign pins_raw = '{sclk: SCLK, ser: SERIAL_IN, strobe: LATCH_STROBE, blank: BLANK};

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pins_meta_ff <= '0;
            pins_sync_ff <= '0;
            pins_last_ff <= '0;
        end else begin
            pins_meta_ff <= pins_raw;
            pins_sync_ff <= pins_meta_ff;
            pins_last_ff <= pins_sync_ff;
        end
    end

    // edge and level decode
    wire sclk_rise = pins_sync_ff.sclk && !pins_last_ff.sclk;
    wire sclk_fall = !pins_sync_ff.sclk && pins_last_ff.sclk;
    wire strobe_rise = pins_sync_ff.strobe && !pins_last_ff.strobe;
    wire ser_bit = pins_sync_ff.ser;
    wire blank_lvl = pins_sync_ff.blank;

    ////////////////////////////////////////////////////////////////////////////
    // grayscale shift register, 288 bits, channel 23 shifted in first
    assign nxt_shift = sclk_rise ? {shift_ff[GSL_FRAME_BITS-2:0], ser_bit} : shift_ff;

    // cascade stage past the msb, moved on falling edges only
    assign nxt_cascade = sclk_fall ? shift_ff[GSL_FRAME_BITS-1] : cascade_ff;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            shift_ff <= GSL_FRAME_RESET;
            cascade_ff <= GSL_BIT_RESET;
        end else begin
            shift_ff <= nxt_shift;
            cascade_ff <= nxt_cascade;
        end
    end

    assign CASCADE_SERIAL_OUT = cascade_ff;

    ////////////////////////////////////////////////////////////////////////////
    // latch loader: snapshot on strobe rise, hold until the fifo accepts it
    wire load_idle = (load_state_ff == GSL_ST_IDLE);
    wire load_pend = (load_state_ff == GSL_ST_PEND);
    wire fifo_push = load_pend;
    wire push_done = load_pend && fifo_in_ready;

    // a newer strobe while pending replaces the older snapshot
    assign nxt_snapshot = strobe_rise ? shift_ff : snapshot_ff;

    always_comb begin
        nxt_load_state = load_state_ff;
        case (load_state_ff)
            GSL_ST_IDLE: begin
                if (strobe_rise) begin
                    nxt_load_state = GSL_ST_PEND;
                end
            end
            GSL_ST_PEND: begin
                if (push_done && !strobe_rise) begin
                    nxt_load_state = GSL_ST_IDLE;
                end
            end
            default: begin
                nxt_load_state = GSL_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            load_state_ff <= GSL_ST_IDLE;
            snapshot_ff <= GSL_FRAME_RESET;
        end else begin
            load_state_ff <= nxt_load_state;
            snapshot_ff <= nxt_snapshot;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame fifo between the shift side and the display latch
    gsl_fifo #(
        .WIDTH(GSL_FRAME_BITS),
        .DEPTH(GSL_FIFO_DEPTH)
    ) u_frame_fifo (
        .clk(CLK),
        .rst_n(RST_N),
        .in_valid(fifo_push),
        .in_data(snapshot_ff),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out_data),
        .out_ready(period_start)
    );

    ////////////////////////////////////////////////////////////////////////////
    // display period: counter wraps every 4096 steps, blank holds it at zero
    assign period_start = (cnt_ff == GSL_CNT_RESET) && !blank_lvl;
    wire latch_take = period_start && fifo_out_valid;

    assign nxt_cnt = blank_lvl ? GSL_CNT_RESET : cnt_ff + GSL_CNT_STEP;

    // new frame enters the latch at a period start
    assign nxt_gray_latch = latch_take ? fifo_out_data : gray_latch_ff;

    // strobe blanks until the next period; set wins over clear
    assign nxt_hold_off = strobe_rise ? 1'b1 : (period_start ? 1'b0 : hold_off_ff);

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            cnt_ff <= GSL_CNT_RESET;
            gray_latch_ff <= GSL_FRAME_RESET;
            hold_off_ff <= GSL_BIT_RESET;
        end else begin
            cnt_ff <= nxt_cnt;
            gray_latch_ff <= nxt_gray_latch;
            hold_off_ff <= nxt_hold_off;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-channel pwm compare, high means sinking current
    wire sink_enable = !blank_lvl && !hold_off_ff;

    generate
        for (genvar ch = 0; ch < GSL_CHANNELS; ch++) begin : g_chan
            wire gsl_gray_t level = gray_latch_ff[ch*GSL_GRAY_BITS +: GSL_GRAY_BITS];
            assign nxt_sink[ch] = sink_enable && (cnt_ff < level);
        end
    endgenerate

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            sink_ff <= '0;
        end else begin
            sink_ff <= nxt_sink;
        end
    end

    assign CHANNEL_SINK_OUTPUT = sink_ff;

    ////////////////////////////////////////////////////////////////////////////
    // assertions on the shift path
    a_shift_capture: assert property (@(posedge CLK) disable iff (!RST_N)
        sclk_rise |=> shift_ff[0] == $past(ser_bit))
        else $error("shift bit 0 did not take the serial input");

    a_shift_move: assert property (@(posedge CLK) disable iff (!RST_N)
        sclk_rise |=> shift_ff[GSL_FRAME_BITS-1:1] == $past(shift_ff[GSL_FRAME_BITS-2:0]))
        else $error("shift register did not move toward the msb");

    a_shift_hold: assert property (@(posedge CLK) disable iff (!RST_N)
        !sclk_rise |=> $stable(shift_ff))
        else $error("shift register moved without a clock rise");

    a_cascade_msb: assert property (@(posedge CLK) disable iff (!RST_N)
        sclk_fall |=> cascade_ff == $past(shift_ff[GSL_FRAME_BITS-1]))
        else $error("cascade stage did not take the msb on a fall");

    a_cascade_falls: assert property (@(posedge CLK) disable iff (!RST_N)
        !sclk_fall |=> $stable(CASCADE_SERIAL_OUT))
        else $error("cascade output changed without a falling edge");

    ////////////////////////////////////////////////////////////////////////////
    // assertions on the latch and display path
    a_latch_snapshot: assert property (@(posedge CLK) disable iff (!RST_N)
        strobe_rise |=> load_pend && snapshot_ff == $past(shift_ff))
        else $error("strobe rise did not capture the shift register");

    a_latch_push: assert property (@(posedge CLK) disable iff (!RST_N)
        push_done && !strobe_rise |=> load_idle)
        else $error("loader stayed pending after the fifo took the frame");

    a_latch_take: assert property (@(posedge CLK) disable iff (!RST_N)
        latch_take |=> gray_latch_ff == $past(fifo_out_data))
        else $error("display latch missed the queued frame");

    a_hold_off: assert property (@(posedge CLK) disable iff (!RST_N)
        strobe_rise |=> hold_off_ff ##1 CHANNEL_SINK_OUTPUT == '0)
        else $error("channels not forced off after strobe rise");

    a_hold_release: assert property (@(posedge CLK) disable iff (!RST_N)
        hold_off_ff && period_start && !strobe_rise |=> !hold_off_ff)
        else $error("hold off not released at the period start");

    a_cnt_runs: assert property (@(posedge CLK) disable iff (!RST_N)
        strobe_rise && !blank_lvl |=> cnt_ff == $past(cnt_ff) + GSL_CNT_STEP)
        else $error("counter disturbed by strobe rise");

    a_blank_clear: assert property (@(posedge CLK) disable iff (!RST_N)
        blank_lvl |=> cnt_ff == GSL_CNT_RESET && CHANNEL_SINK_OUTPUT == '0)
        else $error("blank did not clear counter and outputs");

    a_pwm_ch0: assert property (@(posedge CLK) disable iff (!RST_N)
        sink_enable |=> CHANNEL_SINK_OUTPUT[0] ==
            ($past(cnt_ff) < $past(gray_latch_ff[GSL_GRAY_BITS-1:0])))
        else $error("channel 0 on-time does not follow its latched value");

    a_pwm_repeat: assert property (@(posedge CLK) disable iff (!RST_N)
        !blank_lvl && cnt_ff == '1 |=> cnt_ff == GSL_CNT_RESET)
        else $error("pwm period did not wrap to repeat");

    ////////////////////////////////////////////////////////////////////////////
    // scenario coverage
    c_strobe_load: cover property (@(posedge CLK) disable iff (!RST_N)
        strobe_rise ##[1:8] push_done);

    c_frame_shown: cover property (@(posedge CLK) disable iff (!RST_N)
        latch_take ##1 !hold_off_ff ##1 CHANNEL_SINK_OUTPUT != '0);

    c_cascade_out: cover property (@(posedge CLK) disable iff (!RST_N)
        sclk_fall ##1 CASCADE_SERIAL_OUT);

    c_blank_release: cover property (@(posedge CLK) disable iff (!RST_N)
        blank_lvl ##1 !blank_lvl);

    c_fifo_full: cover property (@(posedge CLK) disable iff (!RST_N)
        load_pend && !fifo_in_ready);

endmodule : gsl_top
`default_nettype wire

// ---- gsl_ctrl_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module gsl_ctrl_model
    import gsl_pkg::*;
(
    output logic SCLK,
    output logic SERIAL_IN,
    output logic LATCH_STROBE,
    input wire logic CASCADE_SERIAL_OUT
);
    ////////////////////////////////////////////////////////////////////////////
    // half of the 125 ns link clock period
    localparam realtime half_period = 62.5;
    // cascade level seen at the end of each low and each high phase
    logic lo_smp [GSL_FRAME_BITS];
    logic hi_smp [GSL_FRAME_BITS];

    // link idle: clock low, strobe low
    initial begin
        SCLK = 1'b0;
        SERIAL_IN = 1'b0;
        LATCH_STROBE = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one device frame, msb first; the link clock stands still outside it
    task automatic send_frame(input gsl_frame_t frame);
        #1; // step off the caller's clock edge so no pin moves on it
        for (int k = 0; k < GSL_FRAME_BITS; k++) begin
            SERIAL_IN = frame[GSL_FRAME_BITS-1-k];
            #(half_period);
            lo_smp[k] = CASCADE_SERIAL_OUT;
            SCLK = 1'b1;
            #(half_period);
            hi_smp[k] = CASCADE_SERIAL_OUT;
            SCLK = 1'b0;
        end
        #(half_period);
        SERIAL_IN = ~SERIAL_IN; // data no longer valid
    endtask : send_frame

    // strobe pulse, then keep the link clock quiet well past 100 ns
    task automatic strobe();
        LATCH_STROBE = 1'b1;
        #50;
        LATCH_STROBE = 1'b0;
        #100;
    endtask : strobe
endmodule : gsl_ctrl_model
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import gsl_pkg::*;
;
    logic clk;
    logic rst_n;
    logic blank;
    logic sclk;
    logic ser;
    logic strobe;
    logic cascade;
    gsl_chan_t chan;
    int failures = 0;
    int checks = 0;
    int cyc = 0;
    int at_a;
    int at_b;
    int lit;
    gsl_frame_t frame_a;
    gsl_frame_t frame_b;

    ////////////////////////////////////////////////////////////////////////////
    // design and controller model
    gsl_top dut (
        .CLK(clk), .RST_N(rst_n), .SCLK(sclk), .SERIAL_IN(ser),
        .LATCH_STROBE(strobe), .BLANK(blank),
        .CASCADE_SERIAL_OUT(cascade), .CHANNEL_SINK_OUTPUT(chan)
    );
    gsl_ctrl_model ctrl (
        .SCLK(sclk), .SERIAL_IN(ser), .LATCH_STROBE(strobe),
        .CASCADE_SERIAL_OUT(cascade)
    );

    // 100 mhz clock and cycle count
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    ////////////////////////////////////////////////////////////////////////////
    // compare and report
    task automatic check_bit(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit

    task automatic check_num(input string what, input int exp, input int got);
        checks++;
        if (got != exp) begin
            failures++;
            $display("ERROR %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check_num

    task automatic check_chan(input string what, input gsl_chan_t exp, input gsl_chan_t got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check_chan

    task automatic wrap_up();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up

    ////////////////////////////////////////////////////////////////////////////
    // helpers: frame builder, turn-on finder, duty counter
    function automatic gsl_frame_t make_frame(input int base, input int step);
        gsl_frame_t f;
        for (int i = 0; i < GSL_CHANNELS; i++) begin
            f[GSL_GRAY_BITS*i +: GSL_GRAY_BITS] = gsl_gray_t'(base + step * i);
        end
        return f;
    endfunction : make_frame

    // cycle of the next rise of channel 0; lit counts lit cycles before it
    task automatic wait_on(output int at, output int n_lit);
        logic prev;
        prev = 1'b1;
        at = -1;
        n_lit = 0;
        for (int n = 0; n < 3 * GSL_PWM_STEPS && at < 0; n++) begin
            @(posedge clk);
            #1;
            if (prev === 1'b0 && chan[0] === 1'b1) at = cyc;
            else if (chan !== '0) n_lit++;
            prev = chan[0];
        end
        check_bit("channel turn-on seen", 1'b1, at >= 0);
    endtask : wait_on

    // on-cycles of every channel over one full period
    task automatic measure_pwm(input string what, input gsl_frame_t f);
        int ons [GSL_CHANNELS] = '{default: 0};
        int unk = 0;
        repeat (GSL_PWM_STEPS) begin
            @(posedge clk);
            #1;
            unk += int'($isunknown(chan));
            for (int i = 0; i < GSL_CHANNELS; i++) ons[i] += int'(chan[i] === 1'b1);
        end
        check_num("unknown output cycles", 0, unk);
        for (int i = 0; i < GSL_CHANNELS; i++) begin
            check_num(what, int'(f[GSL_GRAY_BITS*i +: GSL_GRAY_BITS]), ons[i]);
        end
    endtask : measure_pwm

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_first_load();
        frame_a = make_frame(4095, 178);
        frame_a[GSL_GRAY_BITS +: GSL_GRAY_BITS] = 12'h000;
        ctrl.send_frame(frame_a);
        fork
            ctrl.strobe();
            begin
                repeat (6) @(posedge clk);
                wait_on(at_a, lit);
            end
        join
        check_num("dark before first load", 0, lit);
        measure_pwm("first frame duty", frame_a);
        $display("test first_load done");
    endtask : t_first_load

    task automatic t_reload();
        frame_b = make_frame(100, 150);
        ctrl.send_frame(frame_b);
        for (int k = 0; k < GSL_FRAME_BITS; k++) begin
            check_bit("cascade at rise", frame_a[GSL_FRAME_BITS-1-k], ctrl.lo_smp[k]);
            check_bit("cascade at fall", frame_a[GSL_FRAME_BITS-1-k], ctrl.hi_smp[k]);
        end
        fork
            ctrl.strobe();
            begin
                repeat (6) @(posedge clk);
                wait_on(at_b, lit);
            end
        join
        check_num("dark after strobe", 0, lit);
        check_num("period phase kept", 0, (at_b - at_a) % GSL_PWM_STEPS);
        measure_pwm("second frame duty", frame_b);
        $display("test reload done");
    endtask : t_reload

    task automatic t_blank();
        int t;
        @(posedge clk);
        blank <= 1'b1;
        repeat (5) @(posedge clk);
        repeat (20) begin
            @(posedge clk);
            #1;
            check_chan("blanked outputs", '0, chan);
        end
        @(posedge clk);
        blank <= 1'b0;
        t = cyc;
        wait_on(at_b, lit);
        check_bit("restart after blank", 1'b1, (at_b - t) inside {[1:8]});
        measure_pwm("duty after blank", frame_b);
        $display("test blank done");
    endtask : t_blank

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rst_n = 1'b0;
        blank = 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_first_load();
        t_reload();
        t_blank();
        wrap_up();
    end

    // watchdog: tests need about 21000 cycles
    initial begin
        repeat (40000) @(posedge clk);
        failures++;
        $display("ERROR watchdog expected finish seen hang");
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
